/* hw/scb_pkg.sv */
// Behaviour
// - Full reset after reset input sampled high two consecutive machine cycles.
// - Port outputs forced to one immediately when reset input rises.
// - One machine cycle is formed from every twelve oscillator cycles.
// - Input clock first passes a divide-by-two stage.
// - Registers load defined reset values; stack 07, port latches FF, serial buffer kept, others zero.
// - Unimplemented register addresses read arbitrary data; writes do nothing defined.
// - Program memory spans 000 to FFF; outside targets are flagged.
// - No external data or program memory; external moves are unsupported.
// - Internal data memory is 128 bytes; stack lives inside it.
// - Lock bit one blocks programming; both bits also block verify.
// - Lock bits clear only through a whole-array chip erase.
// - Idle stops the CPU; peripherals run; RAM and registers kept.
// - Idle ends on any enabled interrupt request or hardware reset.
// - Power-down halts everything, keeps RAM, until next hardware reset.
// - Port 3 bit 6 reads the comparator output, not general I/O.
// - A port bit whose latch is one acts as a pulled-up input.
// - Five interrupt vectors with two priority levels at standard addresses.
// - Fully static logic; correct at any clock rate down to zero.
// - Reset reinitialises registers but leaves internal RAM unchanged.
// - RAM writes blocked when idle ends by reset, before reset takes over.
// - Internal reset issued about 15 ms after brown-out recovery.
package scb_pkg;

  // ---------------------------------------------------------------
  // Register offsets in the special function space
  // ---------------------------------------------------------------
  localparam logic [7:0] SCB_STACK_POINTER = 8'h81;
  localparam logic [7:0] SCB_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] SCB_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] SCB_POWER_CONTROL = 8'h87;
  localparam logic [7:0] SCB_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] SCB_TIMER_MODE = 8'h89;
  localparam logic [7:0] SCB_TIMER0_COUNT_LOW = 8'h8A;
  localparam logic [7:0] SCB_TIMER1_COUNT_LOW = 8'h8B;
  localparam logic [7:0] SCB_TIMER0_COUNT_HIGH = 8'h8C;
  localparam logic [7:0] SCB_TIMER1_COUNT_HIGH = 8'h8D;
  localparam logic [7:0] SCB_PORT1_LATCH = 8'h90;
  localparam logic [7:0] SCB_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] SCB_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] SCB_INTERRUPT_ENABLE = 8'hA8;
  localparam logic [7:0] SCB_PORT3_LATCH = 8'hB0;
  localparam logic [7:0] SCB_INTERRUPT_PRIORITY = 8'hB8;
  localparam logic [7:0] SCB_PROGRAM_STATUS_WORD = 8'hD0;
  localparam logic [7:0] SCB_MAIN_ARITH_REG = 8'hE0;
  localparam logic [7:0] SCB_MULTIPLY_AUX_REG = 8'hF0;
  // Block-specific control and status
  localparam logic [7:0] SCB_LOCK_CONTROL = 8'hC0;
  localparam logic [7:0] SCB_SYSTEM_STATUS = 8'hC1;
  localparam logic [7:0] SCB_FETCH_ADDR_LOW = 8'hC2;
  localparam logic [7:0] SCB_FETCH_ADDR_HIGH = 8'hC3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SCB_SP_RESET = 8'h07;
  localparam logic [7:0] SCB_PORT_RESET = 8'hFF;
  localparam logic [7:0] SCB_ZERO_RESET = 8'h00;
  localparam logic [7:0] SCB_UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SCB_POWER_CONTROL_IDLE_BIT = 0;
  localparam int SCB_POWER_CONTROL_PDOWN_BIT = 1;
  localparam int SCB_IE_GLOBAL_BIT = 7;
  localparam int SCB_COMPARATOR_BIT = 6;
  localparam int SCB_LOCK_PROG_BIT = 0;
  localparam int SCB_LOCK_BOTH_BIT = 1;
  localparam int SCB_LOCK_ERASE_BIT = 7;
  // Implemented bits of partial registers, and the interrupt vector count
  localparam logic [7:0] SCB_POWER_CONTROL_MASK = 8'h8F;
  localparam logic [7:0] SCB_IE_MASK = 8'h9F;
  localparam logic [7:0] SCB_IP_MASK = 8'h1F;
  localparam logic [3:0] SCB_INT_VECTORS = 4'h5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SCB_CLK_MHZ = 100;
  localparam int SCB_OSC_PER_MACHINE = 12;
  localparam int SCB_RESET_MACHINE_CYCLES = 2;
  localparam int SCB_BROWNOUT_MS = 15;
  localparam int SCB_BROWNOUT_CYCLES = SCB_BROWNOUT_MS * 1000 * SCB_CLK_MHZ;
  localparam logic [11:0] SCB_PROG_TOP = 12'hFFF;
  localparam int SCB_RAM_BYTES = 128;

endpackage : scb_pkg

/* hw/scb_sys_ctrl.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module scb_sys_ctrl #(
  parameter int BROWNOUT_CYCLES = scb_pkg::SCB_BROWNOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic brownout_pin,
  input wire logic comparator_in,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port3_pin_in,
  input wire logic [4:0] int_request,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic external_move_instruction,
  input wire logic ram_write_req,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe_n,
  output logic [7:0] port3_out,
  output logic [7:0] port3_oe_n,
  output logic machine_tick,
  output logic cpu_run,
  output logic periph_run,
  output logic ram_write_en,
  output logic core_reset,
  output logic lock_bit_one,
  output logic lock_bit_two,
  output logic prog_allowed,
  output logic verify_allowed,
  output logic fetch_fault
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SCB_RUN, SCB_IDLE, SCB_PDOWN} scb_mode_t;

  typedef struct packed {
    logic [1:0] pin_sync1;
    logic [1:0] pin_sync2;
    logic [7:0] p1_sync1;
    logic [7:0] p1_sync2;
    logic [7:0] p3_sync1;
    logic [7:0] p3_sync2;
    logic [4:0] irq_sync1;
    logic [4:0] irq_sync2;
    logic cmp_sync1;
    logic cmp_sync2;
    logic div2;
    logic [2:0] phase;
    logic [1:0] rst_count;
    logic [26:0] bo_count;
    logic bo_pending;
    scb_mode_t mode;
    logic [7:0] sp;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] power_control;
    logic [7:0] timer_control;
    logic [7:0] timer_mode;
    logic [7:0] tl0;
    logic [7:0] tl1;
    logic [7:0] th0;
    logic [7:0] th1;
    logic [7:0] p1;
    logic [7:0] serial_control;
    logic [7:0] serial_buffer;
    logic [7:0] ie;
    logic [7:0] p3;
    logic [7:0] ip;
    logic [7:0] program_status_word;
    logic [7:0] acc;
    logic [7:0] bax;
    logic lb1;
    logic lb2;
    logic fault;
    logic [15:0] fault_addr;
    logic [7:0] rdata;
    logic [7:0] p1_out;
    logic [7:0] p3_out;
    logic tick;
    logic cpu_run;
    logic periph_run;
    logic ram_we;
    logic core_rst;
    logic prog_ok;
    logic verify_ok;
  } scb_state_t;

  scb_state_t state_reg;
  scb_state_t state_next;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] scb_pin_view(input logic [7:0] latch,
                                              input logic [7:0] pins);
    // Latch one leaves the bit pulled up, so the pin decides
    return latch & pins;
  endfunction : scb_pin_view

  function automatic logic scb_hit(input logic [7:0] a,
                                   input logic [7:0] b);
    return a == b;
  endfunction : scb_hit

  logic reset_level;
  logic reset_held;
  logic bo_fire;
  logic wake;
  logic [7:0] p3_view;

  // Synchronised reset; the raw pin is kept only for the port override
  assign reset_level = state_reg.pin_sync2[0];
  assign reset_held = state_reg.rst_count ==
    2'(scb_pkg::SCB_RESET_MACHINE_CYCLES);
  assign bo_fire = state_reg.bo_pending &&
    state_reg.bo_count == 27'(BROWNOUT_CYCLES - 1);
  assign wake = state_reg.ie[scb_pkg::SCB_IE_GLOBAL_BIT] &&
    |(state_reg.irq_sync2 & state_reg.ie[4:0]);

  always_comb begin
    p3_view = scb_pin_view(state_reg.p3, state_reg.p3_sync2);
    p3_view[scb_pkg::SCB_COMPARATOR_BIT] = state_reg.cmp_sync2;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pin_sync1 = {brownout_pin, reset_pin};
    state_next.pin_sync2 = state_reg.pin_sync1;
    state_next.p1_sync1 = port1_pin_in;
    state_next.p1_sync2 = state_reg.p1_sync1;
    state_next.p3_sync1 = port3_pin_in;
    state_next.p3_sync2 = state_reg.p3_sync1;
    state_next.irq_sync1 = int_request;
    state_next.irq_sync2 = state_reg.irq_sync1;
    state_next.cmp_sync1 = comparator_in;
    state_next.cmp_sync2 = state_reg.cmp_sync1;
    state_next.tick = 1'b0;
    state_next.rdata = scb_pkg::SCB_UNMAPPED_READ;

    // Oscillator divided by two, then six phases: twelve per machine cycle
    if (state_reg.mode != SCB_PDOWN) begin
      state_next.div2 = ~state_reg.div2;
      if (state_reg.div2) begin
        if (state_reg.phase == 3'(scb_pkg::SCB_OSC_PER_MACHINE / 2 - 1)) begin
          state_next.phase = 3'h0;
          state_next.tick = 1'b1;
        end else begin
          state_next.phase = state_reg.phase + 3'h1;
        end
      end
    end

    // Qualify the reset pin per machine cycle; power-down stops the
    // oscillator, so the synchronised level wakes it unqualified
    if (!reset_level) begin
      state_next.rst_count = 2'h0;
    end else if (state_reg.mode == SCB_PDOWN) begin
      state_next.mode = SCB_RUN;
    end else if (state_reg.tick && !reset_held) begin
      state_next.rst_count = state_reg.rst_count + 2'h1;
    end

    // Brown-out recovery delay
    if (state_reg.pin_sync2[1]) begin
      state_next.bo_pending = 1'b1;
      state_next.bo_count = 27'h0;
    end else if (state_reg.bo_pending) begin
      state_next.bo_count = state_reg.bo_count + 27'h1;
      if (bo_fire) begin
        state_next.bo_pending = 1'b0;
      end
    end

    // Register bus; reads work in every mode, writes only while running
    if (reg_read) begin
      unique case (reg_addr)
        scb_pkg::SCB_STACK_POINTER: state_next.rdata = state_reg.sp;
        scb_pkg::SCB_DATA_POINTER_LOW: state_next.rdata = state_reg.data_pointer_low;
        scb_pkg::SCB_DATA_POINTER_HIGH: state_next.rdata = state_reg.data_pointer_high;
        scb_pkg::SCB_POWER_CONTROL: state_next.rdata = state_reg.power_control;
        scb_pkg::SCB_TIMER_CONTROL: state_next.rdata = state_reg.timer_control;
        scb_pkg::SCB_TIMER_MODE: state_next.rdata = state_reg.timer_mode;
        scb_pkg::SCB_TIMER0_COUNT_LOW: state_next.rdata = state_reg.tl0;
        scb_pkg::SCB_TIMER1_COUNT_LOW: state_next.rdata = state_reg.tl1;
        scb_pkg::SCB_TIMER0_COUNT_HIGH: state_next.rdata = state_reg.th0;
        scb_pkg::SCB_TIMER1_COUNT_HIGH: state_next.rdata = state_reg.th1;
        scb_pkg::SCB_PORT1_LATCH:
          state_next.rdata = scb_pin_view(state_reg.p1, state_reg.p1_sync2);
        scb_pkg::SCB_SERIAL_CONTROL: state_next.rdata = state_reg.serial_control;
        scb_pkg::SCB_SERIAL_BUFFER: state_next.rdata = state_reg.serial_buffer;
        scb_pkg::SCB_INTERRUPT_ENABLE: state_next.rdata = state_reg.ie;
        scb_pkg::SCB_PORT3_LATCH: state_next.rdata = p3_view;
        scb_pkg::SCB_INTERRUPT_PRIORITY: state_next.rdata = state_reg.ip;
        scb_pkg::SCB_PROGRAM_STATUS_WORD: state_next.rdata = state_reg.program_status_word;
        scb_pkg::SCB_MAIN_ARITH_REG: state_next.rdata = state_reg.acc;
        scb_pkg::SCB_MULTIPLY_AUX_REG: state_next.rdata = state_reg.bax;
        scb_pkg::SCB_LOCK_CONTROL:
          state_next.rdata = {6'h00, state_reg.lb2, state_reg.lb1};
        scb_pkg::SCB_SYSTEM_STATUS:
          state_next.rdata = {3'h0, state_reg.bo_pending, state_reg.fault,
                              reset_held, 2'(state_reg.mode)};
        scb_pkg::SCB_FETCH_ADDR_LOW:
          state_next.rdata = state_reg.fault_addr[7:0];
        scb_pkg::SCB_FETCH_ADDR_HIGH:
          state_next.rdata = state_reg.fault_addr[15:8];
        // Unlisted addresses give a fixed zero, a legal arbitrary value
        default: state_next.rdata = scb_pkg::SCB_UNMAPPED_READ;
      endcase
    end

    // Writes land only while running; idle keeps every register
    if (reg_write && state_reg.mode == SCB_RUN) begin
      if (scb_hit(reg_addr, scb_pkg::SCB_STACK_POINTER)) begin
        // Stack stays inside the 128-byte internal RAM
        state_next.sp = {1'b0, reg_wdata[6:0]};
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_DATA_POINTER_LOW)) begin
        state_next.data_pointer_low = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_DATA_POINTER_HIGH)) begin
        state_next.data_pointer_high = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_POWER_CONTROL)) begin
        state_next.power_control = reg_wdata & scb_pkg::SCB_POWER_CONTROL_MASK;
        if (reg_wdata[scb_pkg::SCB_POWER_CONTROL_PDOWN_BIT]) begin
          state_next.mode = SCB_PDOWN;
        end else if (reg_wdata[scb_pkg::SCB_POWER_CONTROL_IDLE_BIT]) begin
          state_next.mode = SCB_IDLE;
        end
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_TIMER_CONTROL)) begin
        state_next.timer_control = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_TIMER_MODE)) begin
        state_next.timer_mode = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_TIMER0_COUNT_LOW)) begin
        state_next.tl0 = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_TIMER1_COUNT_LOW)) begin
        state_next.tl1 = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_TIMER0_COUNT_HIGH)) begin
        state_next.th0 = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_TIMER1_COUNT_HIGH)) begin
        state_next.th1 = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_PORT1_LATCH)) begin
        state_next.p1 = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_SERIAL_CONTROL)) begin
        state_next.serial_control = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_SERIAL_BUFFER)) begin
        state_next.serial_buffer = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_INTERRUPT_ENABLE)) begin
        state_next.ie = reg_wdata & scb_pkg::SCB_IE_MASK;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_PORT3_LATCH)) begin
        state_next.p3 = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_INTERRUPT_PRIORITY)) begin
        state_next.ip = reg_wdata & scb_pkg::SCB_IP_MASK;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_PROGRAM_STATUS_WORD)) begin
        state_next.program_status_word = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_MAIN_ARITH_REG)) begin
        state_next.acc = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_MULTIPLY_AUX_REG)) begin
        state_next.bax = reg_wdata;
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_LOCK_CONTROL)) begin
        // Lock bits only ever program; erase alone clears both
        if (reg_wdata[scb_pkg::SCB_LOCK_ERASE_BIT]) begin
          state_next.lb1 = 1'b0;
          state_next.lb2 = 1'b0;
        end else begin
          state_next.lb1 = state_reg.lb1 |
            reg_wdata[scb_pkg::SCB_LOCK_PROG_BIT];
          state_next.lb2 = state_reg.lb2 |
            reg_wdata[scb_pkg::SCB_LOCK_BOTH_BIT];
        end
      end
      if (scb_hit(reg_addr, scb_pkg::SCB_SYSTEM_STATUS)) begin
        state_next.fault = 1'b0;
      end
    end

    // Idle ends on an enabled request; the idle bit drops with it
    if (state_reg.mode == SCB_IDLE && wake) begin
      state_next.mode = SCB_RUN;
      state_next.power_control[scb_pkg::SCB_POWER_CONTROL_IDLE_BIT] = 1'b0;
    end

    // Fetch range and external access checks; a new fault beats a clear
    if (fetch_valid && (fetch_addr > 16'(scb_pkg::SCB_PROG_TOP) ||
                        external_move_instruction)) begin
      state_next.fault = 1'b1;
      state_next.fault_addr = fetch_addr;
    end

    // Pins go high from the raw pin at once, ahead of qualification
    state_next.p1_out = (reset_pin || reset_held) ?
      scb_pkg::SCB_PORT_RESET : state_next.p1;
    state_next.p3_out = (reset_pin || reset_held) ?
      scb_pkg::SCB_PORT_RESET : state_next.p3;
    state_next.p3_out[scb_pkg::SCB_COMPARATOR_BIT] = 1'b1;
    state_next.cpu_run = state_next.mode == SCB_RUN && !reset_held;
    state_next.periph_run = state_next.mode != SCB_PDOWN;
    // Reset seen during idle locks RAM until the sequence takes over
    state_next.ram_we = ram_write_req && state_next.mode == SCB_RUN &&
      !reset_level && !reset_held;
    state_next.core_rst = reset_held || bo_fire;
    state_next.prog_ok = !state_next.lb1 && !state_next.lb2;
    state_next.verify_ok = !(state_next.lb1 && state_next.lb2);

    // Qualified reset reloads registers; RAM is outside this block
    if (reset_held || bo_fire) begin
      state_next.mode = SCB_RUN;
      state_next.sp = scb_pkg::SCB_SP_RESET;
      state_next.data_pointer_low = scb_pkg::SCB_ZERO_RESET;
      state_next.data_pointer_high = scb_pkg::SCB_ZERO_RESET;
      state_next.power_control = scb_pkg::SCB_ZERO_RESET;
      state_next.timer_control = scb_pkg::SCB_ZERO_RESET;
      state_next.timer_mode = scb_pkg::SCB_ZERO_RESET;
      state_next.tl0 = scb_pkg::SCB_ZERO_RESET;
      state_next.tl1 = scb_pkg::SCB_ZERO_RESET;
      state_next.th0 = scb_pkg::SCB_ZERO_RESET;
      state_next.th1 = scb_pkg::SCB_ZERO_RESET;
      state_next.p1 = scb_pkg::SCB_PORT_RESET;
      state_next.serial_control = scb_pkg::SCB_ZERO_RESET;
      state_next.ie = scb_pkg::SCB_ZERO_RESET;
      state_next.p3 = scb_pkg::SCB_PORT_RESET;
      state_next.ip = scb_pkg::SCB_ZERO_RESET;
      state_next.program_status_word = scb_pkg::SCB_ZERO_RESET;
      state_next.acc = scb_pkg::SCB_ZERO_RESET;
      state_next.bax = scb_pkg::SCB_ZERO_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Registers; plain edge flops, no dynamic nodes, so any rate works
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.mode <= SCB_RUN;
      state_reg.sp <= scb_pkg::SCB_SP_RESET;
      state_reg.p1 <= scb_pkg::SCB_PORT_RESET;
      state_reg.p3 <= scb_pkg::SCB_PORT_RESET;
      state_reg.p1_out <= scb_pkg::SCB_PORT_RESET;
      state_reg.p3_out <= scb_pkg::SCB_PORT_RESET;
      state_reg.periph_run <= 1'b1;
      state_reg.core_rst <= 1'b1;
      state_reg.prog_ok <= 1'b1;
      state_reg.verify_ok <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign port1_out = state_reg.p1_out;
  // Drive low only for zero bits; ones float on the pull-up
  assign port1_oe_n = state_reg.p1_out;
  assign port3_out = state_reg.p3_out;
  assign port3_oe_n = state_reg.p3_out;
  assign machine_tick = state_reg.tick;
  assign cpu_run = state_reg.cpu_run;
  assign periph_run = state_reg.periph_run;
  assign ram_write_en = state_reg.ram_we;
  assign core_reset = state_reg.core_rst;
  assign lock_bit_one = state_reg.lb1;
  assign lock_bit_two = state_reg.lb2;
  assign prog_allowed = state_reg.prog_ok;
  assign verify_allowed = state_reg.verify_ok;
  assign fetch_fault = state_reg.fault;

endmodule : scb_sys_ctrl

/* tb/scb_sys_ctrl_asserts.sv */
`timescale 1ns/10ps
module scb_sys_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe_n,
  input wire logic [7:0] port3_out,
  input wire logic [7:0] port3_oe_n,
  input wire logic machine_tick,
  input wire logic cpu_run,
  input wire logic periph_run,
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  input wire logic prog_allowed,
  input wire logic verify_allowed,
  input wire logic fetch_fault,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
  sequence s_quiet;
    !machine_tick [*8] ##1 !machine_tick [*3];
  endsequence
  property p_tick;
    machine_tick |=> s_quiet ##1 (machine_tick || !periph_run);
  endproperty
  a_tick: assert property (p_tick) else $error("tick period wrong");
  property p_pin_ports;
    reset_pin |=> port1_out == 8'hFF && port3_out == 8'hFF;
  endproperty
  a_pin_ports: assert property (p_pin_ports) else $error("ports not high");
  property p_oe;
    port1_oe_n == port1_out && port3_oe_n == port3_out;
  endproperty
  a_oe: assert property (p_oe) else $error("enable differs");
  property p_p36;
    port3_oe_n[6] && port3_out[6];
  endproperty
  a_p36: assert property (p_p36) else $error("bit six driven");
  property p_lock_mode;
    prog_allowed == !(lock_bit_one || lock_bit_two) &&
      verify_allowed == !(lock_bit_one && lock_bit_two);
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("lock mode");
  property p_lock_keep;
    lock_bit_one && !(reg_write && reg_addr == 8'hC0 && reg_wdata[7])
      |=> lock_bit_one;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock lost");
  property p_fetch;
    fetch_valid && fetch_addr > 16'h0FFF |=> fetch_fault;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fault");
  property p_idle;
    reg_write && reg_addr == 8'h87 && reg_wdata[0] && cpu_run |=> !cpu_run;
  endproperty
  a_idle: assert property (p_idle) else $error("cpu still runs");
  c_read: cover property (reg_read ##1 reg_rdata != 8'h00);
  c_fault: cover property ($rose(fetch_fault));
  c_both: cover property (lock_bit_one && lock_bit_two);
endmodule : scb_sys_ctrl_asserts

/* tb/scb_sys_ctrl_tb.sv */
`timescale 1ns/10ps
module scb_sys_ctrl_tb;
  logic clk = 1'h0, rst = 1'h1, reset_pin = 1'h0, brownout_pin = 1'h0;
  logic comparator_in = 1'h1, fetch_valid = 1'h0, ext_mv = 1'h0;
  logic ram_write_req = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
  logic [7:0] p1_in = 8'hFF, p3_in = 8'hFF, reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00, d;
  logic [4:0] int_request = 5'h00;
  logic [15:0] fetch_addr = 16'h0000;
  logic [7:0] reg_rdata, port1_out, port1_oe_n, port3_out, port3_oe_n;
  logic machine_tick, cpu_run, periph_run, ram_write_en, core_reset;
  logic lock_bit_one, lock_bit_two, prog_allowed, verify_allowed;
  logic fetch_fault;
  int failures = 0, n_tests = 0, i, k;
  // Address, reset value, written value, value read back
  logic [31:0] rows [18] = '{32'h8107FF7F, 32'h8200A5A5, 32'h83005A5A,
    32'h88003C3C, 32'h8900C3C3, 32'h8A001111, 32'h8B002222, 32'h8C003333,
    32'h8D004444, 32'h90FF0000, 32'h98006666, 32'hA8007F1F, 32'hB0FF0F4F,
    32'hB800FF1F, 32'hD0007777, 32'hE0008888, 32'hF0009999, 32'h85000000};
  always #5 clk = ~clk;
  scb_sys_ctrl #(.BROWNOUT_CYCLES(20)) dut (.clk(clk), .rst(rst),
    .reset_pin(reset_pin), .brownout_pin(brownout_pin),
    .comparator_in(comparator_in), .port1_pin_in(p1_in),
    .port3_pin_in(p3_in), .int_request(int_request),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .external_move_instruction(ext_mv), .ram_write_req(ram_write_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .port1_out(port1_out),
    .port1_oe_n(port1_oe_n), .port3_out(port3_out),
    .port3_oe_n(port3_oe_n), .machine_tick(machine_tick),
    .cpu_run(cpu_run), .periph_run(periph_run),
    .ram_write_en(ram_write_en), .core_reset(core_reset),
    .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two),
    .prog_allowed(prog_allowed), .verify_allowed(verify_allowed),
    .fetch_fault(fetch_fault));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    cyc(1);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    cyc(1);
    reg_read <= 1'h0;
    d = reg_rdata;
  endtask : rd
  task automatic fetch(input logic [15:0] a, input logic x);
    @(posedge clk);
    fetch_valid <= 1'h1;
    fetch_addr <= a;
    ext_mv <= x;
    cyc(1);
    fetch_valid <= 1'h0;
    ext_mv <= 1'h0;
    cyc(1);
  endtask : fetch
  // Bounded wait for core_reset to reach a level
  task automatic wait_rst(input logic v);
    for (k = 0; k < 100 && core_reset !== v; k++) cyc(1);
  endtask : wait_rst
  task automatic print_verdict;
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    for (i = 0; i < 18; i++) begin
      rd(rows[i][31:24]);
      chk(d, rows[i][23:16]);
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24]);
      chk(d, rows[i][7:0]);
    end
    comparator_in <= 1'h0;
    cyc(1);
    rd(8'hB0);
    chk({d, port3_out}, 16'h0F4F);
    wr(8'h90, 8'hF0);
    p1_in <= 8'h3C;
    cyc(1);
    rd(8'h90);
    chk({d, port1_oe_n}, 16'h30F0);
    for (k = 0; k < 20 && machine_tick !== 1'h1; k++) cyc(1);
    cyc(1);
    for (k = 1; k < 30 && machine_tick !== 1'h1; k++) cyc(1);
    chk(16'(k), 16'h000C);
    wr(8'hC0, 8'h01);
    chk({lock_bit_one, lock_bit_two, prog_allowed, verify_allowed}, 4'h9);
    wr(8'hC0, 8'h02);
    wr(8'hC0, 8'h00);
    rd(8'hC0);
    chk({d, lock_bit_one, lock_bit_two, verify_allowed}, 11'h01E);
    wr(8'hC0, 8'h80);
    chk({lock_bit_one, lock_bit_two, prog_allowed, verify_allowed}, 4'h3);
    fetch(16'h0FFF, 1'h0);
    chk(fetch_fault, 1'h0);
    fetch(16'h1000, 1'h0);
    rd(8'hC3);
    chk({fetch_fault, d}, 9'h110);
    wr(8'hC1, 8'h00);
    chk(fetch_fault, 1'h0);
    fetch(16'h0010, 1'h1);
    chk(fetch_fault, 1'h1);
    ram_write_req <= 1'h1;
    wr(8'hA8, 8'h81);
    chk(ram_write_en, 1'h1);
    wr(8'h87, 8'h01);
    wr(8'h82, 8'h3C);
    rd(8'h82);
    chk({cpu_run, periph_run, ram_write_en, d}, 11'h2A5);
    int_request <= 5'h01;
    for (k = 0; k < 20 && cpu_run !== 1'h1; k++) cyc(1);
    chk(cpu_run, 1'h1);
    int_request <= 5'h00;
    wr(8'h87, 8'h03);
    int_request <= 5'h01;
    cyc(10);
    chk({cpu_run, periph_run}, 2'h0);
    int_request <= 5'h00;
    reset_pin <= 1'h1;
    cyc(1);
    chk({port1_out, core_reset}, 9'h1FE);
    wait_rst(1'h1);
    chk(core_reset, 1'h1);
    reset_pin <= 1'h0;
    wait_rst(1'h0);
    rd(8'h82);
    chk({cpu_run, ram_write_en, d}, 10'h300);
    brownout_pin <= 1'h1;
    cyc(3);
    brownout_pin <= 1'h0;
    cyc(10);
    chk(core_reset, 1'h0);
    wait_rst(1'h1);
    chk(core_reset, 1'h1);
    print_verdict();
  end
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
endmodule : scb_sys_ctrl_tb
bind scb_sys_ctrl scb_sys_ctrl_asserts u_chk (.clk(clk), .rst(rst),
  .reset_pin(reset_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .port1_out(port1_out), .port1_oe_n(port1_oe_n), .port3_out(port3_out),
  .port3_oe_n(port3_oe_n), .machine_tick(machine_tick), .cpu_run(cpu_run),
  .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two),
  .prog_allowed(prog_allowed), .verify_allowed(verify_allowed),
  .fetch_fault(fetch_fault), .fetch_addr(fetch_addr),
  .fetch_valid(fetch_valid), .periph_run(periph_run));
